// >>> hdl/lso_pkg.sv
/*
 * Shared constants and types of the limit switch output block: register map,
 * point configuration layout, watch data types and the state records.
 * Assumes a 32-bit AXI4-Lite register bus with 12-bit byte addresses.
 */
`default_nettype none

package lso_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int unsigned LSO_NPT    = 32;
   localparam int unsigned LSO_NWATCH = 8;
   localparam int unsigned LSO_AW     = 12;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [11:0] LSO_CTRL_OFS  = 12'h000;
   localparam logic [11:0] LSO_STAT_OFS  = 12'h004;
   localparam logic [11:0] LSO_OUT_OFS   = 12'h008;
   localparam logic [11:0] LSO_PT_BASE   = 12'h100;
   localparam logic [11:0] LSO_PT_END    = 12'h500;
   localparam int unsigned LSO_PT_IDX_LSB = 5;
   localparam int unsigned LSO_PT_IDX_MSB = 9;
   localparam int unsigned LSO_PT_WRD_LSB = 2;
   localparam int unsigned LSO_PT_WRD_MSB = 4;
   localparam logic [2:0]  LSO_W_CFG      = 3'h0;
   localparam logic [2:0]  LSO_W_START_LO = 3'h1;
   localparam logic [2:0]  LSO_W_START_HI = 3'h2;
   localparam logic [2:0]  LSO_W_END_LO   = 3'h3;
   localparam logic [2:0]  LSO_W_END_HI   = 3'h4;
   localparam logic [2:0]  LSO_PT_NWORD   = 3'h5;
   localparam int unsigned LSO_CTRL_READY_BIT = 0;
   localparam int unsigned LSO_STAT_READY_BIT = 0;
   localparam logic [31:0] LSO_CFG_MASK   = 32'h0007_1F37;
   localparam logic [31:0] LSO_CFG_RST    = 32'h0000_0000;
   localparam logic [63:0] LSO_VAL_RST    = 64'h0000_0000_0000_0000;
   localparam logic [1:0]  LSO_RESP_OKAY  = 2'h0;
   localparam logic [1:0]  LSO_RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      LSO_INT16 = 2'h0,
      LSO_INT32 = 2'h1,
      LSO_FP64  = 2'h2,
      LSO_RSVT  = 2'h3
   } lso_dtype_t;

   typedef struct packed {
      logic [12:0] rsv3;
      logic [2:0]  watch_sel;
      logic [2:0]  rsv2;
      logic [4:0]  out_bit;
      logic [1:0]  rsv1;
      lso_dtype_t  dtype;
      logic        rsv0;
      logic        frc_cfg;
      logic        en_cfg;
      logic        point_on;
   } lso_cfg_t;

   typedef struct packed {
      logic        valid;
      logic [11:0] addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } lso_wr_t;

   typedef struct packed {
      logic        aw_rdy;
      logic        w_rdy;
      logic        aw_full;
      logic        w_full;
      logic [11:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        ar_rdy;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } lso_slv_st_t;

   typedef struct packed {
      logic                         ctrl_ready;
      logic                         ctrl_prev;
      logic                         motion_ready;
      logic                         eval_go;
      logic [LSO_NPT-1:0]           limit_out;
      logic [LSO_NPT-1:0][31:0]     cfg;
      logic [LSO_NPT-1:0][63:0]     sh_start;
      logic [LSO_NPT-1:0][63:0]     sh_end;
      logic [LSO_NPT-1:0][63:0]     act_start;
      logic [LSO_NPT-1:0][63:0]     act_end;
   } lso_top_st_t;

endpackage

`default_nettype wire

// >>> hdl/lso_point_eval.sv
/*
 * Region test of one limit point: maps watch, start and end value to an
 * order-preserving unsigned key by data type and applies the region table.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/10ps
`default_nettype none

module lso_point_eval
   import lso_pkg::*;
(
   input  wire logic [63:0] watch_i,
   input  wire logic [63:0] start_i,
   input  wire logic [63:0] end_i,
   input  wire lso_dtype_t  dtype_i,
   output logic             region_o
);

   // ---------------------------------------------------------------
   // Signed value to unsigned order key
   // ---------------------------------------------------------------
   function automatic logic [63:0] order_key(input logic [63:0] v, input lso_dtype_t t);
      logic [63:0] k;
      k = 64'h0;
      case (t)
         LSO_INT16: k = {{48{v[15]}}, v[15:0]} ^ 64'h8000_0000_0000_0000;
         LSO_FP64: begin
            if (v[63]) begin
               k = ~v;
            end else begin
               k = v ^ 64'h8000_0000_0000_0000;
            end
         end
         default: k = {{32{v[31]}}, v[31:0]} ^ 64'h8000_0000_0000_0000;
      endcase
      return k;
   endfunction

   logic [63:0] key_w;
   logic [63:0] key_s;
   logic [63:0] key_e;

   always_comb begin
      key_w = order_key(watch_i, dtype_i);
      key_s = order_key(start_i, dtype_i);
      key_e = order_key(end_i, dtype_i);
      if (key_s < key_e) begin
         region_o = (key_w >= key_s) && (key_w < key_e);
      end else if (key_s > key_e) begin
         region_o = (key_w >= key_s) || (key_w < key_e);
      end else begin
         region_o = 1'b0;
      end
   end

endmodule

`default_nettype wire

// >>> hdl/lso_axil_slave.sv
/*
 * AXI4-Lite slave front end: takes write address and data in either order,
 * issues one write strobe toward the register file, answers reads with the
 * data the register file decodes from the read address at the taking edge.
 * Assumes the register file answers wr_err_i and rd_* combinationally.
 */
`timescale 1ns/10ps
`default_nettype none

module lso_axil_slave
   import lso_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [11:0] awaddr_i,
   input  wire logic        awvalid_i,
   output logic             awready_o,
   input  wire logic [31:0] wdata_i,
   input  wire logic [3:0]  wstrb_i,
   input  wire logic        wvalid_i,
   output logic             wready_o,
   output logic [1:0]       bresp_o,
   output logic             bvalid_o,
   input  wire logic        bready_i,
   input  wire logic        arvalid_i,
   output logic             arready_o,
   output logic [31:0]      rdata_o,
   output logic [1:0]       rresp_o,
   output logic             rvalid_o,
   input  wire logic        rready_i,
   output lso_wr_t          wr_o,
   input  wire logic        wr_err_i,
   input  wire logic [31:0] rd_data_i,
   input  wire logic        rd_err_i
);

   lso_slv_st_t s;
   lso_slv_st_t next_s;
   logic        fire;

   // ---------------------------------------------------------------
   // Channel handshakes
   // ---------------------------------------------------------------
   always_comb begin
      next_s = s;
      fire   = s.aw_full && s.w_full && !s.bvalid;
      if (awvalid_i && s.aw_rdy) begin
         next_s.aw_rdy  = 1'b0;
         next_s.aw_full = 1'b1;
         next_s.aw_addr = awaddr_i;
      end
      if (wvalid_i && s.w_rdy) begin
         next_s.w_rdy  = 1'b0;
         next_s.w_full = 1'b1;
         next_s.w_data = wdata_i;
         next_s.w_strb = wstrb_i;
      end
      if (fire) begin
         next_s.aw_full = 1'b0;
         next_s.w_full  = 1'b0;
         next_s.aw_rdy  = 1'b1;
         next_s.w_rdy   = 1'b1;
         next_s.bvalid  = 1'b1;
         next_s.bresp   = wr_err_i ? LSO_RESP_SLVERR : LSO_RESP_OKAY;
      end else if (s.bvalid && bready_i) begin
         next_s.bvalid = 1'b0;
      end
      if (arvalid_i && s.ar_rdy) begin
         next_s.ar_rdy = 1'b0;
         next_s.rvalid = 1'b1;
         next_s.rdata  = rd_data_i;
         next_s.rresp  = rd_err_i ? LSO_RESP_SLVERR : LSO_RESP_OKAY;
      end else if (s.rvalid && rready_i) begin
         next_s.rvalid = 1'b0;
         next_s.ar_rdy = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s        <= '0;
         s.aw_rdy <= 1'b1;
         s.w_rdy  <= 1'b1;
         s.ar_rdy <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign awready_o  = s.aw_rdy;
   assign wready_o   = s.w_rdy;
   assign bvalid_o   = s.bvalid;
   assign bresp_o    = s.bresp;
   assign arready_o  = s.ar_rdy;
   assign rvalid_o   = s.rvalid;
   assign rdata_o    = s.rdata;
   assign rresp_o    = s.rresp;
   assign wr_o.valid = fire;
   assign wr_o.addr  = s.aw_addr;
   assign wr_o.data  = s.w_data;
   assign wr_o.strb  = s.w_strb;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_write_answer: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      fire |=> s.bvalid && !s.aw_full && !s.w_full)
      else $error("write strobe not followed by response");

   a_read_hold: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (s.rvalid && !rready_i) |=> s.rvalid && $stable(s.rdata) && !s.ar_rdy)
      else $error("read answer dropped before rready");

endmodule

`default_nettype wire

// >>> hdl/lso_limit_out.sv
/*
 * Limit switch output block: 32 points, each comparing a selected watch value
 * against a start/end region and driving one of 32 output bits, gated by the
 * controller ready handshake and refreshed on every motion cycle tick.
 * Assumes watch values, enable/force bits and the cycle tick come from logic
 * on SYS_CLK_I; software reaches the registers over AXI4-Lite.
 */
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
// Operation
// - Thirty-two limit points exist regardless of how many axes are in use.
// - Start, end and watch values are compared as signed quantities.
// - With start below end a point is on for start <= watch < end.
// - With start above end the region wraps: on for watch >= start or watch < end.
// - With start equal to end a point is never on.
// - Outputs are evaluated only while motion ready is set, which follows the controller ready rise.
// - Start and end are copied in on the controller ready rise and again on each motion cycle.
// - Any number of points may share a watch value or an output bit.
// - A configured enable bit passes the region result when 1 and blocks it when 0.
// - A point without an enable bit is always enabled.
// - A configured force bit at 1 turns the point on, overriding a cleared enable.
// - A point without a force bit is never forced.
// - Each output bit is the OR of the final results of all points aimed at it.
// - The watch value is a 16-bit integer, 32-bit integer or 64-bit float per point.
// - Start and end use the same type as the point's watch value.
`timescale 1ns/10ps
`default_nettype none

module lso_limit_out
   import lso_pkg::*;
(
   input  wire logic                              SYS_CLK_I,
   input  wire logic                              RST_N_I,
   input  wire logic                              CYCLE_TICK_I,
   input  wire logic [LSO_NWATCH-1:0][63:0]       WATCH_DATA_I,
   input  wire logic [LSO_NPT-1:0]                ENABLE_BITS_I,
   input  wire logic [LSO_NPT-1:0]                FORCE_BITS_I,
   input  wire logic [11:0]                       AXI_AWADDR_I,
   input  wire logic                              AXI_AWVALID_I,
   output logic                                   AXI_AWREADY_O,
   input  wire logic [31:0]                       AXI_WDATA_I,
   input  wire logic [3:0]                        AXI_WSTRB_I,
   input  wire logic                              AXI_WVALID_I,
   output logic                                   AXI_WREADY_O,
   output logic [1:0]                             AXI_BRESP_O,
   output logic                                   AXI_BVALID_O,
   input  wire logic                              AXI_BREADY_I,
   input  wire logic [11:0]                       AXI_ARADDR_I,
   input  wire logic                              AXI_ARVALID_I,
   output logic                                   AXI_ARREADY_O,
   output logic [31:0]                            AXI_RDATA_O,
   output logic [1:0]                             AXI_RRESP_O,
   output logic                                   AXI_RVALID_O,
   input  wire logic                              AXI_RREADY_I,
   output logic [LSO_NPT-1:0]                     LIMIT_OUT_O,
   output logic                                   MOTION_READY_O
);

   lso_top_st_t               s;
   lso_top_st_t               next_s;
   lso_wr_t                   wr;
   logic                      wr_err;
   logic [31:0]               rd_data;
   logic                      rd_err;
   logic [LSO_NPT-1:0]        region;
   logic [LSO_NPT-1:0]        final_pt;
   logic [LSO_NPT-1:0]        or_out;
   logic [63:0]               watch0;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic pt_hit(input logic [11:0] a);
      logic [11:0] rel;
      rel = a - LSO_PT_BASE;
      return (a >= LSO_PT_BASE) && (a < LSO_PT_END) && (rel[LSO_PT_WRD_MSB:LSO_PT_WRD_LSB] < LSO_PT_NWORD)
             && (rel[1:0] == 2'h0);
   endfunction

   // ---------------------------------------------------------------
   // Bus front end
   // ---------------------------------------------------------------
   lso_axil_slave u_slave (
      .clk_i     (SYS_CLK_I),
      .rst_n_i   (RST_N_I),
      .awaddr_i  (AXI_AWADDR_I),
      .awvalid_i (AXI_AWVALID_I),
      .awready_o (AXI_AWREADY_O),
      .wdata_i   (AXI_WDATA_I),
      .wstrb_i   (AXI_WSTRB_I),
      .wvalid_i  (AXI_WVALID_I),
      .wready_o  (AXI_WREADY_O),
      .bresp_o   (AXI_BRESP_O),
      .bvalid_o  (AXI_BVALID_O),
      .bready_i  (AXI_BREADY_I),
      .arvalid_i (AXI_ARVALID_I),
      .arready_o (AXI_ARREADY_O),
      .rdata_o   (AXI_RDATA_O),
      .rresp_o   (AXI_RRESP_O),
      .rvalid_o  (AXI_RVALID_O),
      .rready_i  (AXI_RREADY_I),
      .wr_o      (wr),
      .wr_err_i  (wr_err),
      .rd_data_i (rd_data),
      .rd_err_i  (rd_err)
   );

   assign wr_err = !((wr.addr == LSO_CTRL_OFS) || (wr.addr == LSO_STAT_OFS) || (wr.addr == LSO_OUT_OFS)
                     || pt_hit(wr.addr));

   // Read decode
   always_comb begin
      logic [11:0] rel;
      logic [4:0]  idx;
      rel     = AXI_ARADDR_I - LSO_PT_BASE;
      idx     = rel[LSO_PT_IDX_MSB:LSO_PT_IDX_LSB];
      rd_data = 32'h0000_0000;
      rd_err  = 1'b0;
      if (AXI_ARADDR_I == LSO_CTRL_OFS) begin
         rd_data[LSO_CTRL_READY_BIT] = s.ctrl_ready;
      end else if (AXI_ARADDR_I == LSO_STAT_OFS) begin
         rd_data[LSO_STAT_READY_BIT] = s.motion_ready;
      end else if (AXI_ARADDR_I == LSO_OUT_OFS) begin
         rd_data = s.limit_out;
      end else if (pt_hit(AXI_ARADDR_I)) begin
         case (rel[LSO_PT_WRD_MSB:LSO_PT_WRD_LSB])
            LSO_W_CFG:      rd_data = s.cfg[idx];
            LSO_W_START_LO: rd_data = s.sh_start[idx][31:0];
            LSO_W_START_HI: rd_data = s.sh_start[idx][63:32];
            LSO_W_END_LO:   rd_data = s.sh_end[idx][31:0];
            default:        rd_data = s.sh_end[idx][63:32];
         endcase
      end else begin
         rd_err = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Per-point evaluation
   // ---------------------------------------------------------------
   generate
      for (genvar p = 0; p < LSO_NPT; p++) begin : g_pt
         lso_cfg_t c;
         assign c = lso_cfg_t'(s.cfg[p]);
         lso_point_eval u_eval (
            .watch_i  (WATCH_DATA_I[c.watch_sel]),
            .start_i  (s.act_start[p]),
            .end_i    (s.act_end[p]),
            .dtype_i  (c.dtype),
            .region_o (region[p])
         );
         assign final_pt[p] = c.point_on && ((c.frc_cfg && FORCE_BITS_I[p])
                              || ((!c.en_cfg || ENABLE_BITS_I[p]) && region[p]));
      end
   endgenerate

   always_comb begin
      or_out = '0;
      for (int p = 0; p < LSO_NPT; p++) begin
         if (final_pt[p]) begin
            or_out[s.cfg[p][12:8]] = 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Register writes and ready sequencing
   // ---------------------------------------------------------------
   always_comb begin
      logic [11:0] rel;
      logic [4:0]  idx;
      rel    = wr.addr - LSO_PT_BASE;
      idx    = rel[LSO_PT_IDX_MSB:LSO_PT_IDX_LSB];
      next_s = s;
      next_s.ctrl_prev = s.ctrl_ready;
      next_s.eval_go   = 1'b0;
      if (wr.valid) begin
         if (wr.addr == LSO_CTRL_OFS) begin
            if (wr.strb[0]) begin
               next_s.ctrl_ready = wr.data[LSO_CTRL_READY_BIT];
            end
         end else if (pt_hit(wr.addr)) begin
            case (rel[LSO_PT_WRD_MSB:LSO_PT_WRD_LSB])
               LSO_W_CFG:      next_s.cfg[idx] = merge_bytes(s.cfg[idx], wr.data, wr.strb) & LSO_CFG_MASK;
               LSO_W_START_LO: next_s.sh_start[idx][31:0] = merge_bytes(s.sh_start[idx][31:0], wr.data, wr.strb);
               LSO_W_START_HI: next_s.sh_start[idx][63:32] = merge_bytes(s.sh_start[idx][63:32], wr.data, wr.strb);
               LSO_W_END_LO:   next_s.sh_end[idx][31:0] = merge_bytes(s.sh_end[idx][31:0], wr.data, wr.strb);
               default:        next_s.sh_end[idx][63:32] = merge_bytes(s.sh_end[idx][63:32], wr.data, wr.strb);
            endcase
         end
      end
      if (s.ctrl_ready && !s.ctrl_prev) begin
         next_s.motion_ready = 1'b1;
         next_s.act_start    = s.sh_start;
         next_s.act_end      = s.sh_end;
         next_s.eval_go      = 1'b1;
      end else if (!s.ctrl_ready && s.ctrl_prev) begin
         next_s.motion_ready = 1'b0;
         next_s.limit_out    = '0;
      end else if (s.motion_ready && CYCLE_TICK_I) begin
         next_s.act_start = s.sh_start;
         next_s.act_end   = s.sh_end;
         next_s.eval_go   = 1'b1;
      end
      if (s.eval_go && s.motion_ready && s.ctrl_ready) begin
         next_s.limit_out = or_out;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign LIMIT_OUT_O    = s.limit_out;
   assign MOTION_READY_O = s.motion_ready;
   assign watch0         = WATCH_DATA_I[s.cfg[0][18:16]];

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_out_off_idle: assert property (
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      !s.motion_ready |-> (s.limit_out == '0))
      else $error("outputs on while not ready");

   a_ready_follows: assert property (
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      $rose(s.ctrl_ready) |=> s.motion_ready ##0 s.eval_go)
      else $error("motion ready did not follow controller ready");

   a_fall_clears: assert property (
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      $fell(s.ctrl_ready) |=> !s.motion_ready && (s.limit_out == '0))
      else $error("outputs not cleared on ready fall");

   a_tick_reload: assert property (
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (s.motion_ready && s.ctrl_ready && s.ctrl_prev && CYCLE_TICK_I)
      |=> (s.act_start[0] == $past(s.sh_start[0])) && (s.act_end[0] == $past(s.sh_end[0])) && s.eval_go)
      else $error("region values not reloaded on cycle tick");

   a_region_normal: assert property (
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (s.cfg[0][5:4] == LSO_INT32 && $signed(s.act_start[0][31:0]) < $signed(s.act_end[0][31:0]))
      |-> region[0] == ($signed(watch0[31:0]) >= $signed(s.act_start[0][31:0])
                        && $signed(watch0[31:0]) < $signed(s.act_end[0][31:0])))
      else $error("normal region result wrong");

   a_region_wrap: assert property (
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (s.cfg[0][5:4] == LSO_INT16 && $signed(s.act_start[0][15:0]) > $signed(s.act_end[0][15:0]))
      |-> region[0] == ($signed(watch0[15:0]) >= $signed(s.act_start[0][15:0])
                        || $signed(watch0[15:0]) < $signed(s.act_end[0][15:0])))
      else $error("wrapped region result wrong");

   a_region_equal: assert property (
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (s.act_start[0] == s.act_end[0]) |-> !region[0])
      else $error("equal bounds gave an active region");

   a_force_wins: assert property (
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (s.cfg[0][0] && s.cfg[0][2] && FORCE_BITS_I[0]) |-> final_pt[0])
      else $error("forced point not active");

   a_enable_off: assert property (
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (s.cfg[0][1] && !ENABLE_BITS_I[0] && !(s.cfg[0][2] && FORCE_BITS_I[0])) |-> !final_pt[0])
      else $error("disabled point contributed");

   a_or_output: assert property (
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (s.eval_go && s.motion_ready && s.ctrl_ready && final_pt[0])
      |=> s.limit_out[$past(s.cfg[0][12:8])])
      else $error("active point did not drive its output bit");

endmodule

`default_nettype wire

// >>> tb/lso_partner.sv
/* Far side model: motion cycle tick source and watch data lanes.
   Assumes the block's clock and reset. */
`timescale 1ns/10ps
`default_nettype none
module lso_partner
   import lso_pkg::*;
(
   input  wire logic                   clk_i,
   input  wire logic                   rst_n_i,
   input  wire logic [31:0]            val_i,
   output logic                        tick_o,
   output logic [LSO_NWATCH-1:0][63:0] watch_o
);
   logic [1:0] cnt;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) cnt <= 2'h0;
      else cnt <= cnt + 2'h1;
   end
   assign tick_o  = (cnt == 2'h3);
   // Upper word junk: int32 points must ignore it
   assign watch_o = {LSO_NWATCH{32'hA5A5_5A5A, val_i}};
endmodule
`default_nettype wire

// >>> tb/testbench.sv
/* Self-checking bench of the limit output block.
   Assumes lso_pkg and the partner model are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import lso_pkg::*;
   logic clk, rst_n, awv, wv, brdy, arv, rrdy, smp, tick;
   logic [11:0] awa, ara;
   logic [31:0] wd, val, en, fr, r, w, lo, rdat;
   logic [1:0] bresp, rresp;
   logic [LSO_NWATCH-1:0][63:0] wat;
   logic aw_s, w_s, bv_s, ar_s, rv_s, mr_s, awr, wr_r, bv, arr, rv, mr;
   logic [1:0] br_s, rr_s;
   logic [31:0] rd_s, lo_s;
   logic [63:0] rq[$], bq[$], oq[$];
   int fails, n_checks, cyc, i, e[8];
   lso_partner u_lso_partner (.clk_i(clk), .rst_n_i(rst_n), .val_i(val), .tick_o(tick), .watch_o(wat));
   lso_limit_out u_lso_limit_out (.SYS_CLK_I(clk), .RST_N_I(rst_n), .CYCLE_TICK_I(tick), .WATCH_DATA_I(wat),
      .ENABLE_BITS_I(en), .FORCE_BITS_I(fr), .AXI_AWADDR_I(awa), .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awr),
      .AXI_WDATA_I(wd), .AXI_WSTRB_I(4'hF), .AXI_WVALID_I(wv), .AXI_WREADY_O(wr_r), .AXI_BRESP_O(bresp),
      .AXI_BVALID_O(bv), .AXI_BREADY_I(brdy), .AXI_ARADDR_I(ara), .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr),
      .AXI_RDATA_O(rdat), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rv), .AXI_RREADY_I(rrdy), .LIMIT_OUT_O(lo),
      .MOTION_READY_O(mr));
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   // Snapshot of outputs between edges, race free
   always @(negedge clk) begin
      {aw_s, w_s, bv_s, ar_s, rv_s, mr_s, br_s, rr_s, rd_s, lo_s} <= {awr, wr_r, bv, arr, rv, mr, bresp, rresp, rdat, lo};
   end
   function automatic logic [31:0] lf(input logic [31:0] x);
      lf = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Expected outputs; b is the wrap point's current end value
   function automatic logic [63:0] ex(input logic [31:0] v, input logic [31:0] n, input logic [31:0] f,
                                      input logic [31:0] b);
      ex = 64'h1_0000_0000;
      ex[3] = f[0] | (n[0] & ($signed(v) >= -5) & ($signed(v) < 20));
      ex[4] = ($signed(v) >= 100) | ($signed(v) < $signed(b));
   endfunction
   task automatic cmp(input logic [63:0] x, input logic [63:0] g);
      n_checks++;
      if (g !== x) begin
         fails++;
         $display("ERROR t=%0t exp=%h got=%h", $time, x, g);
      end
   endtask
   task automatic cmp_b(input logic [1:0] x, input logic [1:0] g);
      cmp({62'h0, x}, {62'h0, g});
   endtask
   task automatic cmp_o(input logic [63:0] x, input logic [32:0] g);
      cmp(x, {31'h0, g});
   endtask
   task automatic wra(input logic [11:0] a, input logic [31:0] d, input logic [1:0] x);
      bq.push_back({62'h0, x});
      @(posedge clk);
      {awa, wd, awv, wv, brdy} <= {a, d, 3'h7};
      do begin
         @(posedge clk);
         if (aw_s) awv <= 1'b0;
         if (w_s) wv <= 1'b0;
      end while (!(aw_s && w_s) && (awv || wv));
      do @(posedge clk); while (!bv_s);
      brdy <= 1'b0;
   endtask
   task automatic rda(input logic [11:0] a, input logic [31:0] d, input logic [1:0] x);
      rq.push_back({30'h0, x, d});
      @(posedge clk);
      {ara, arv, rrdy} <= {a, 2'h3};
      do @(posedge clk); while (!ar_s);
      arv <= 1'b0;
      do @(posedge clk); while (!rv_s);
      rrdy <= 1'b0;
   endtask
   task automatic test_done;
      $display("checks=%0d fails=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (rv_s && rrdy) cmp(rq.pop_front(), {30'h0, rr_s, rd_s});
      if (bv_s && brdy) cmp_b(bq.pop_front(), br_s);
      if (smp) cmp_o(oq.pop_front(), {mr_s, lo_s});
      if (cyc > 5000) begin
         fails++;
         test_done;
      end
   end
   initial begin
      {rst_n, awv, wv, brdy, arv, rrdy, smp, awa, ara, wd, val, en, fr} = '0;
      e = '{-5, -6, 19, 20, 29, 30, 100, 7};
      r = 32'ha2bb7e64;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rda(12'h008, 32'h0, LSO_RESP_OKAY);
      rda(12'h114, 32'h0, LSO_RESP_SLVERR);
      wra(12'h114, 32'h1, LSO_RESP_SLVERR);
      // Point 0 gated in band, point 1 wrapping, point 2 empty band
      wra(12'h100, 32'h317, 0);
      wra(12'h104, -5, 0);
      wra(12'h10C, 20, 0);
      wra(12'h120, 32'h411, 0);
      wra(12'h124, 100, 0);
      wra(12'h12C, 30, 0);
      wra(12'h140, 32'h311, 0);
      wra(12'h144, 7, 0);
      wra(12'h14C, 7, 0);
      wra(12'h000, 32'h1, LSO_RESP_OKAY);
      rda(12'h004, 32'h1, LSO_RESP_OKAY);
      // Last pass moves the wrap end while ready; the tick must reload it
      for (i = 0; i < 25; i++) begin
         r = lf(r);
         w = (i < 8) ? e[i] : (i == 24) ? 35 : {{24{r[7]}}, r[7:0]};
         if (i == 24) wra(12'h12C, 40, 0);
         @(posedge clk);
         {val, en, fr} <= {w, r, lf(r)};
         repeat (9) @(posedge clk);
         oq.push_back(ex(w, r, lf(r), (i == 24) ? 40 : 30));
         smp <= 1'b1;
         @(posedge clk);
         smp <= 1'b0;
      end
      wra(12'h000, 32'h0, LSO_RESP_OKAY);
      oq.push_back(64'h0);
      smp <= 1'b1;
      @(posedge clk);
      smp <= 1'b0;
      repeat (2) @(posedge clk);
      test_done;
   end
endmodule
`default_nettype wire
